// File: logic/segment_stream_defs.svh
// Offsets, field positions, reset values and limits of the segment stream framer.
// Assumes inclusion by bare name from files that switch implicit nets off.
`ifndef SEGMENT_STREAM_DEFS_SVH
`define SEGMENT_STREAM_DEFS_SVH
// ***************************************
// Register byte offsets
// ***************************************
`define SSF_CTRL_OFFSET 8'h00
`define SSF_STATUS_OFFSET 8'h04
`define SSF_PKT_CNT_OFFSET 8'h08
`define SSF_LOST_CNT_OFFSET 8'h0C
`define SSF_DROP_CNT_OFFSET 8'h10
`define SSF_FRAME_ERR_OFFSET 8'h14
`define SSF_LEN_ERR_OFFSET 8'h18
`define SSF_LAST_HDR_OFFSET 8'h1C
// ***************************************
// Control fields and reset value
// ***************************************
`define SSF_CTRL_ENABLE_BIT 0
`define SSF_CTRL_CLEAR_BIT 1
`define SSF_CTRL_LINK_LSB 8
`define SSF_CTRL_RESET 32'h0000_FF01
// ***************************************
// Sublayer header fields (32-bit word)
// ***************************************
`define SSF_HDR_CHECK_BIT 31
`define SSF_HDR_SEQV_BIT 30
`define SSF_HDR_EXT_LSB 28
`define SSF_HDR_FLOW_LSB 25
`define SSF_HDR_SEGCNT_LSB 16
`define SSF_HDR_SEQ_LSB 0
// ***************************************
// Segment table entry fields
// ***************************************
`define SSF_ENT_FIRST_BIT 31
`define SSF_ENT_LAST_BIT 30
`define SSF_ENT_LEN_LSB 16
`define SSF_ENT_CHAN_LSB 8
`define SSF_ENT_CSEQ_LSB 4
`define SSF_ENT_PROF_LSB 0
`define SSF_STAMP_BYTES 14'h0004
`define SSF_RESP_OKAY 2'h0
`define SSF_RESP_SLVERR 2'h2
`endif

// File: logic/segment_stream_pkg.sv
// Types shared by the segment stream framer.
// Assumes the defs header is compiled alongside.
`default_nettype none
package segment_stream_pkg;
	// Parser states
	typedef enum logic [1:0] {ST_HEADER, ST_TABLE, ST_PAYLOAD, ST_DRAIN} parse_state_type;
	// Segment kinds
	typedef enum logic {SEG_FRAME, SEG_LINK} seg_kind_type;
endpackage
`default_nettype wire

// File: logic/segment_stream_framer.sv
// Receive-side parser of the segmented stream sublayer: header, table, payload.
// Assumes a byte stream from same-clock logic and an AXI4-Lite master.
// What this block does
// - Circuit-check bit first, sent as zero
// - Sequence number used only when flagged valid
// - Extension bits 00 means this header type
// - Spare bits sent zero, ignored on receive
// - Three-bit flow selector names packet flow
// - Segment count equals table entries and segments
// - Sequence increments per packet; gaps reveal loss
// - Frame segment first flag marks frame start
// - Frame segment last flag marks frame end
// - Fourteen-bit length locates each segment
// - Only outer frames of packet partial
// - Frames reassembled across any packet count
// - Frame-data and link message segments supported
// - Link message blocks never split
// - Entries are 32 bits, header 4+4n bytes
// - Entry holds channel, channel sequence, profile
// - Only 32-bit entry format accepted
// - One layout for all channel types
// - Eight-bit channel identifier per entry
// - Link first flag means timestamp prepended
// - Link last flag sent zero, ignored
// - Flows tracked independently within session
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`include "segment_stream_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module segment_stream_framer import segment_stream_pkg::*; #(
	parameter int MAX_SEGS = 127,
	parameter int FLOWS = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] in_data,
	input wire logic in_valid,
	input wire logic in_last,
	output logic in_ready,
	output logic [7:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic out_frame_start,
	output logic out_frame_end,
	output logic out_link,
	output logic out_stamp,
	output logic [7:0] out_channel,
	output logic [3:0] out_chan_seq,
	output logic [3:0] out_profile,
	output logic [2:0] out_flow
);
	// ***************************************
	// Field helpers
	// ***************************************
	// Segment length of a table entry
	function automatic logic [13:0] entry_len(input logic [31:0] e);
		entry_len = e[`SSF_ENT_LEN_LSB +: 14];
	endfunction
	// Channel identifier of a table entry
	function automatic logic [7:0] entry_chan(input logic [31:0] e);
		entry_chan = e[`SSF_ENT_CHAN_LSB +: 8];
	endfunction

	// ***************************************
	// Storage and state
	// ***************************************
	parse_state_type state; // Parser position
	logic [31:0] seg_table [0:MAX_SEGS-1]; // Whole table is held before payload
	logic [23:0] acc; // Byte accumulator for 32-bit words
	logic [1:0] byte_idx; // Byte within current word
	logic [6:0] seg_cnt; // Segments in this packet
	logic [6:0] tbl_idx; // Entries stored so far
	logic [6:0] seg_idx; // Segment being emitted
	logic [13:0] seg_pos; // Byte within segment
	logic [2:0] flow; // Flow of current packet
	logic [15:0] expect_seq [0:FLOWS-1]; // Next sequence per flow
	logic [FLOWS-1:0] seq_seen; // A sequence was seen per flow
	logic [FLOWS-1:0] in_frame; // Frame open across packets per flow
	logic [31:0] ctrl; // Control register
	logic [31:0] last_hdr; // Last accepted header
	logic [15:0] pkt_cnt, lost_cnt, drop_cnt, frame_err, len_err; // Statistics
	logic aw_held, w_held; // Address and data captured, either order
	logic [7:0] aw_addr; // Captured write address
	logic [31:0] w_data; // Captured write data
	logic [3:0] w_strb; // Byte lanes travel with the data, not the live bus
	wire logic wr_go = aw_held & w_held & ~s_axi_bvalid;
	wire logic wr_ctrl = wr_go & (aw_addr == `SSF_CTRL_OFFSET);

	// ***************************************
	// Decode
	// ***************************************
	wire logic take = in_valid & in_ready;
	wire logic enable = ctrl[`SSF_CTRL_ENABLE_BIT];
	wire logic [7:0] link_chan = ctrl[`SSF_CTRL_LINK_LSB +: 8];
	wire logic [31:0] word = {acc, in_data};
	// Check bit and spare bits are not examined on receive
	wire logic hdr_seqv = word[`SSF_HDR_SEQV_BIT];
	wire logic hdr_ext_ok = word[`SSF_HDR_EXT_LSB +: 2] == 2'h0;
	wire logic [2:0] hdr_flow = word[`SSF_HDR_FLOW_LSB +: 3];
	wire logic [6:0] hdr_segs = word[`SSF_HDR_SEGCNT_LSB +: 7];
	wire logic [15:0] hdr_seq = word[`SSF_HDR_SEQ_LSB +: 16];
	wire logic word_done = take & (byte_idx == 2'h3);
	wire logic [31:0] cur = seg_table[seg_idx];
	wire logic [13:0] cur_len = entry_len(cur);
	// Link segments recognised by channel id
	wire logic cur_link = entry_chan(cur) == link_chan;
	wire logic cur_first = cur[`SSF_ENT_FIRST_BIT];
	// Last flag only counts on frame segments
	wire logic cur_end = cur[`SSF_ENT_LAST_BIT] & ~cur_link;
	wire logic seg_empty = cur_len == 14'h0000;
	wire logic seg_final = seg_idx == seg_cnt - 7'h01;
	wire logic seg_end = seg_empty | (take & (seg_pos == cur_len - 14'h0001));
	wire logic slot_free = ~out_valid | out_ready;
	// Sequence gap, wrap counts as normal step
	wire logic seq_gap = hdr_seqv & seq_seen[hdr_flow] & (hdr_seq != expect_seq[hdr_flow]);
	// Frame start while one is open, or a middle with none open
	wire logic frame_bad = cur_first ? in_frame[flow] : ~in_frame[flow];
	wire logic seg_start = take & (seg_pos == 14'h0000);
	wire logic ev_frame_err = (state == ST_PAYLOAD) & seg_start & ~cur_link & frame_bad;
	wire logic ev_pkt = (state == ST_HEADER) & word_done & hdr_ext_ok;
	wire logic ev_drop = (state == ST_HEADER) & word_done & ~hdr_ext_ok;
	wire logic ev_lost = ev_pkt & seq_gap;
	wire logic short_pkt = take & in_last & (state == ST_TABLE
		| (state == ST_HEADER & ~word_done)
		| (state == ST_PAYLOAD & ~(seg_end & seg_final)));
	wire logic long_pkt = (state == ST_PAYLOAD) & seg_end & seg_final & ~(take & in_last)
		| ev_pkt & hdr_segs == 7'h00 & ~in_last;
	wire logic ev_len_err = short_pkt | long_pkt;

	// Input ready: payload waits on output slot, empty segments stall one cycle
	assign in_ready = enable & ((state != ST_PAYLOAD) | (~seg_empty & slot_free));

	// ***************************************
	// Parser state machine
	// ***************************************
	// Header, table, payload walk
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_HEADER;
			byte_idx <= 2'h0;
			acc <= 24'h000000;
			seg_cnt <= 7'h00;
			tbl_idx <= 7'h00;
			seg_idx <= 7'h00;
			seg_pos <= 14'h0000;
			flow <= 3'h0;
		end else begin
			if (take) begin
				acc <= word[23:0];
				byte_idx <= in_last ? 2'h0 : byte_idx + 2'h1;
			end
			unique case (state)
				ST_HEADER: begin
					if (word_done) begin
						flow <= hdr_flow;
						seg_cnt <= hdr_segs;
						tbl_idx <= 7'h00;
						if (in_last) begin
							// Header alone ends packet
							state <= ST_HEADER;
						end else if (!hdr_ext_ok || hdr_segs == 7'h00) begin
							// Unknown header kind or no segments
							state <= ST_DRAIN;
						end else begin
							state <= ST_TABLE;
						end
					end
				end
				ST_TABLE: begin
					if (take && in_last) begin
						state <= ST_HEADER;
					end else if (word_done) begin
						seg_table[tbl_idx] <= word;
						tbl_idx <= tbl_idx + 7'h01;
						if (tbl_idx == seg_cnt - 7'h01) begin
							// Table complete before first segment
							state <= ST_PAYLOAD;
							seg_idx <= 7'h00;
							seg_pos <= 14'h0000;
						end
					end
				end
				ST_PAYLOAD: begin
					if (seg_end) begin
						// Next segment by table order
						seg_idx <= seg_idx + 7'h01;
						seg_pos <= 14'h0000;
						if (seg_final) begin
							state <= (take & in_last) ? ST_HEADER : ST_DRAIN;
						end
					end else if (take) begin
						seg_pos <= seg_pos + 14'h0001;
					end
					if (take && in_last && !(seg_end && seg_final)) begin
						state <= ST_HEADER;
					end
				end
				ST_DRAIN: begin
					// Discard rest of packet
					if (take && in_last) begin
						state <= ST_HEADER;
					end
				end
			endcase
		end
	end

	// ***************************************
	// Per-flow tracking
	// ***************************************
	// Sequence expectation and open-frame flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seq_seen <= '0;
			in_frame <= '0;
			for (int i = 0; i < FLOWS; i++) begin
				expect_seq[i] <= 16'h0000;
			end
		end else begin
			if (ev_pkt && hdr_seqv) begin
				// Only a flagged sequence is trusted
				expect_seq[hdr_flow] <= hdr_seq + 16'h0001;
				seq_seen[hdr_flow] <= 1'b1;
			end
			if (state == ST_PAYLOAD && seg_start && !cur_link) begin
				// Frame stays open until a last flag
				in_frame[flow] <= ~cur_end;
			end
		end
	end

	// ***************************************
	// Output byte register
	// ***************************************
	// One byte slot; data leaves from flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_valid <= 1'b0;
			out_data <= 8'h00;
			out_frame_start <= 1'b0;
			out_frame_end <= 1'b0;
			out_link <= 1'b0;
			out_stamp <= 1'b0;
			out_channel <= 8'h00;
			out_chan_seq <= 4'h0;
			out_profile <= 4'h0;
			out_flow <= 3'h0;
		end else if (state == ST_PAYLOAD && take) begin
			out_valid <= 1'b1;
			out_data <= in_data;
			out_frame_start <= ~cur_link & cur_first & (seg_pos == 14'h0000);
			out_frame_end <= cur_end & (seg_pos == cur_len - 14'h0001);
			out_link <= cur_link;
			// Leading bytes of a flagged link block are the timestamp
			out_stamp <= cur_link & cur_first & (seg_pos < `SSF_STAMP_BYTES);
			out_channel <= entry_chan(cur);
			out_chan_seq <= cur[`SSF_ENT_CSEQ_LSB +: 4];
			out_profile <= cur[`SSF_ENT_PROF_LSB +: 4];
			out_flow <= flow;
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

	// ***************************************
	// Statistics
	// ***************************************
	// Clear request from control write; a same-cycle event survives the clear
	wire logic clr = wr_ctrl & w_strb[0] & w_data[`SSF_CTRL_CLEAR_BIT];
	always_ff @(posedge aclk) begin
		if (!aresetn || clr) begin
			pkt_cnt <= {15'h0000, ev_pkt & aresetn};
			lost_cnt <= {15'h0000, ev_lost & aresetn};
			drop_cnt <= {15'h0000, ev_drop & aresetn};
			frame_err <= {15'h0000, ev_frame_err & aresetn};
			len_err <= {15'h0000, ev_len_err & aresetn};
			last_hdr <= 32'h0000_0000;
		end else begin
			pkt_cnt <= pkt_cnt + {15'h0000, ev_pkt};
			lost_cnt <= lost_cnt + {15'h0000, ev_lost};
			drop_cnt <= drop_cnt + {15'h0000, ev_drop};
			frame_err <= frame_err + {15'h0000, ev_frame_err};
			len_err <= len_err + {15'h0000, ev_len_err};
			if (ev_pkt) begin
				last_hdr <= word;
			end
		end
	end

	// ***************************************
	// AXI4-Lite slave
	// ***************************************
	wire logic wr_map = aw_addr[7:5] == 3'h0;
	wire logic [7:0] ra = s_axi_araddr;
	wire logic rd_map = ra[7:5] == 3'h0;
	// Read selection
	wire logic [31:0] rd_word =
		(ra[4:2] == 3'h0) ? ctrl :
		(ra[4:2] == 3'h1) ? {24'h000000, 2'h0, state, in_frame[3:0]} :
		(ra[4:2] == 3'h2) ? {16'h0000, pkt_cnt} :
		(ra[4:2] == 3'h3) ? {16'h0000, lost_cnt} :
		(ra[4:2] == 3'h4) ? {16'h0000, drop_cnt} :
		(ra[4:2] == 3'h5) ? {16'h0000, frame_err} :
		(ra[4:2] == 3'h6) ? {16'h0000, len_err} : last_hdr;

	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	// Write path: capture, apply, respond
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SSF_RESP_OKAY;
			ctrl <= `SSF_CTRL_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? `SSF_RESP_OKAY : `SSF_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_ctrl) begin
				// Byte lanes honoured; clear bit is a pulse, never stored
				for (int b = 0; b < 4; b++) begin
					if (w_strb[b]) begin
						ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
					end
				end
				if (w_strb[0]) begin
					ctrl[`SSF_CTRL_CLEAR_BIT] <= 1'b0;
				end
			end
		end
	end

	// Read path: one cycle to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SSF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_map ? rd_word : 32'h0000_0000;
			s_axi_rresp <= rd_map ? `SSF_RESP_OKAY : `SSF_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: dv/segment_stream_framer_props.sv
// Checker of port timing for the segment stream framer.
// Assumes one clock domain and a bind onto the framer top.
`timescale 1ns/1ps
`default_nettype none
module segment_stream_framer_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] out_data,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic out_frame_start,
	input wire logic out_frame_end,
	input wire logic out_link,
	input wire logic out_stamp
);
	// ****************************
	// Properties
	// ****************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Write answered two cycles after both channels taken: capture, then respond
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##1 s_axi_bvalid) else $error("write not answered");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	// Answers stand until taken
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read answer changed");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	// Unmapped place gives an error and zero data
	a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h20
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
	// Payload byte and its link and stamp marks stand while stalled
	a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)
		&& $stable(out_link) && $stable(out_stamp)) else $error("payload changed");
	a_stamp_link: assert property (out_valid && out_stamp |-> out_link)
		else $error("stamp outside link block");
	a_link_marks: assert property (out_valid && out_link |-> !out_frame_end
		&& !out_frame_start) else $error("frame mark on link block");
	cover property (out_valid && out_ready && out_frame_start);
	cover property (out_valid && out_ready && out_stamp);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind segment_stream_framer segment_stream_framer_props chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.out_data, .out_valid, .out_ready, .out_frame_start, .out_frame_end, .out_link, .out_stamp);
`default_nettype wire

// File: dv/packet_source.sv
// Headend packet source feeding the framer's byte stream.
// Assumes the framer's clock; the bench queues headers and bytes.
`timescale 1ns/1ps
`default_nettype none
module packet_source #(
	parameter logic [15:0] SEQ_START = 16'hFFFE // Arbitrary start, near the wrap
) (
	input wire logic aclk,
	input wire logic in_ready,
	output var logic [7:0] in_data = 8'h00,
	output var logic in_valid = 1'b0,
	output var logic in_last = 1'b0
);
	logic [8:0] q[$]; // Pending bytes, last mark on top
	logic [15:0] seq[8]; // Next sequence number per flow
	int gap = 0; // Idle cycles wanted between bytes
	int idle = 0; // Idle cycles so far
	initial foreach (seq[i]) seq[i] = SEQ_START;
	// Word, most significant byte first
	task put_w(input logic [31:0] w);
		for (int i = 3; i >= 0; i--) q.push_back({1'b0, w[i*8+:8]});
	endtask
	// Counting payload bytes, last mark on the final one
	// Payloads stay far below the size cap
	task put_p(input logic [7:0] b, input int n, input logic last);
		for (int i = 0; i < n; i++) q.push_back({last && i == n - 1, b + 8'(i)});
	endtask
	// Header: check and spare bits zero, sequence steps per packet
	task hdr(input logic [2:0] fl, input logic sv, input logic [1:0] ext, input logic [6:0] n);
		put_w({1'b0, sv, ext, fl, 2'h0, n, seq[fl]});
		seq[fl] = seq[fl] + 16'h0001;
	endtask
	// Byte driver: holds until taken, scrambles lines when idle
	always @(posedge aclk) begin
		if (in_valid && !in_ready) begin
			idle = 0;
		end else if (q.size() != 0 && idle >= gap) begin
			idle = 0;
			{in_last, in_data} <= q.pop_front();
			in_valid <= 1'b1;
		end else begin
			idle = idle + 1;
			in_valid <= 1'b0;
			in_last <= 1'b0;
			in_data <= ~in_data;
		end
	end
endmodule
`default_nettype wire

// File: dv/segment_stream_framer_bench.sv
// Bench for the segment stream framer: registers, segments, spans, drops.
// Assumes the packet source model and the checker bound in its own file.
`include "segment_stream_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module segment_stream_framer_bench;
	// ****************************
	// Signals and instances
	// ****************************
	logic aclk = 1'b0, aresetn = 1'b0, stall = 1'b0, out_ready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [7:0] in_data, out_data, out_channel;
	wire logic in_valid, in_last, in_ready, out_valid, out_frame_start, out_frame_end;
	wire logic out_link, out_stamp;
	wire logic [3:0] out_chan_seq, out_profile;
	wire logic [2:0] out_flow;
	logic [30:0] obs[$]; // Payload bytes seen leaving
	int failures = 0;
	int checks = 0;
	always #20 aclk = ~aclk;
	segment_stream_framer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .in_data, .in_valid, .in_last, .in_ready, .out_data,
		.out_valid, .out_ready, .out_frame_start, .out_frame_end, .out_link, .out_stamp,
		.out_channel, .out_chan_seq, .out_profile, .out_flow);
	packet_source src (.aclk, .in_ready, .in_data, .in_valid, .in_last);
	// Far side stalls every other cycle when asked
	always @(posedge aclk) begin
		out_ready <= stall ? ~out_ready : 1'b1;
	end
	// Collector of delivered bytes with their marks
	always @(posedge aclk) begin
		if (aresetn && out_valid && out_ready) begin
			obs.push_back({out_flow, out_frame_start, out_frame_end, out_link, out_stamp,
				out_channel, out_chan_seq, out_profile, out_data});
		end
	end
	// ****************************
	// Shared tasks
	// ****************************
	task report_and_stop;
		if (failures == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task hang;
		failures++;
		$display("[ERR] %0t wait ran out", $time);
		report_and_stop();
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	// Write: both channels offered, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		b = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 60 && !b; n++) begin
			@(negedge aclk); // Ready lines settled for the coming edge
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end
		if (!b) hang();
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, rv;
		rv = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 60 && !rv; n++) begin
			@(negedge aclk);
			ar = s_axi_arvalid && s_axi_arready;
			rv = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (rv) s_axi_rready <= 1'b0;
		end
		if (!rv) hang();
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
	endtask
	// Counter clear through the self-clearing control bit
	task clr;
		wr(`SSF_CTRL_OFFSET, `SSF_CTRL_RESET | 32'h0000_0002);
	endtask
	// Wait until the source is empty and n bytes came out
	task settle(input int n);
		int i;
		for (i = 0; i < 900; i++) begin
			@(posedge aclk);
			if (src.q.size() == 0 && !in_valid && obs.size() >= n) break;
		end
		if (i == 900) hang();
	endtask
	// One segment's bytes; fm holds start, end, link, stamp marks
	task cmp_seg(input logic [2:0] fl, input logic [15:0] cp, input logic [3:0] fm,
		input logic [7:0] b, input int n);
		logic [30:0] e;
		logic [30:0] g;
		for (int i = 0; i < n; i++) begin
			e = {fl, fm[3] && i == 0, fm[2] && i == n - 1, fm[1], fm[0] && i < 4, cp, b + 8'(i)};
			g = (obs.size() != 0) ? obs.pop_front() : 31'h7FFF_FFFF;
			chk({1'h0, g}, {1'h0, e});
		end
	endtask
	// ****************************
	// Scenarios
	// ****************************
	task sc_regs;
		logic [31:0] d;
		logic [1:0] r;
		rdchk(`SSF_CTRL_OFFSET, `SSF_CTRL_RESET);
		rd(8'h20, d, r);
		chk({30'h0, r}, {30'h0, `SSF_RESP_SLVERR});
		chk(d, 32'h0);
		clr();
		rdchk(`SSF_CTRL_OFFSET, `SSF_CTRL_RESET);
	endtask
	// Frame segment then link block with stamp in one packet
	task sc_segs;
		clr();
		src.hdr(3'h5, 1'h1, 2'h0, 7'h2);
		src.put_w({2'h3, 14'h2, 16'h0312});
		src.put_w({2'h2, 14'h6, 16'hFF34});
		src.put_p(8'hA0, 2, 1'h0);
		src.put_p(8'h10, 6, 1'h1);
		settle(8);
		cmp_seg(3'h5, 16'h0312, 4'hC, 8'hA0, 2);
		cmp_seg(3'h5, 16'hFF34, 4'h3, 8'h10, 6);
		rdchk(`SSF_PKT_CNT_OFFSET, 32'h1);
		rdchk(`SSF_LEN_ERR_OFFSET, 32'h0);
		rdchk(`SSF_LAST_HDR_OFFSET, 32'h4A02_FFFE);
	endtask
	// Frame over three packets, sequence wrap, gap, unflagged number
	task sc_span;
		clr();
		stall = 1'b1;
		src.gap = 2;
		src.hdr(3'h1, 1'h1, 2'h0, 7'h1);
		src.put_w({2'h2, 14'h3, 16'h0700});
		src.put_p(8'h20, 3, 1'h1);
		src.hdr(3'h1, 1'h1, 2'h0, 7'h1);
		src.put_w({2'h0, 14'h2, 16'h0700});
		src.put_p(8'h30, 2, 1'h1);
		src.hdr(3'h1, 1'h1, 2'h0, 7'h2);
		src.put_w({2'h1, 14'h2, 16'h0700});
		src.put_w({2'h3, 14'h1, 16'h0700});
		src.put_p(8'h40, 3, 1'h1);
		settle(8);
		cmp_seg(3'h1, 16'h0700, 4'h8, 8'h20, 3);
		cmp_seg(3'h1, 16'h0700, 4'h0, 8'h30, 2);
		cmp_seg(3'h1, 16'h0700, 4'h4, 8'h40, 2);
		cmp_seg(3'h1, 16'h0700, 4'hC, 8'h42, 1);
		rdchk(`SSF_FRAME_ERR_OFFSET, 32'h0);
		rdchk(`SSF_LOST_CNT_OFFSET, 32'h0);
		src.seq[1] = src.seq[1] + 16'h0001;
		src.hdr(3'h1, 1'h1, 2'h0, 7'h1);
		src.put_w({2'h3, 14'h1, 16'h0700});
		src.put_p(8'h60, 1, 1'h1);
		src.seq[1] = src.seq[1] + 16'h0001;
		src.hdr(3'h1, 1'h0, 2'h0, 7'h1);
		src.put_w({2'h3, 14'h1, 16'h0700});
		src.put_p(8'h70, 1, 1'h1);
		settle(2);
		obs.delete();
		rdchk(`SSF_LOST_CNT_OFFSET, 32'h1);
		rdchk(`SSF_PKT_CNT_OFFSET, 32'h5);
		stall = 1'b0;
		src.gap = 0;
	endtask
	// Foreign header dropped whole, then a stray middle piece
	task sc_drop;
		clr();
		src.hdr(3'h2, 1'h1, 2'h1, 7'h1);
		src.put_w({2'h3, 14'h2, 16'h0700});
		src.put_p(8'h80, 2, 1'h1);
		src.hdr(3'h2, 1'h1, 2'h0, 7'h1);
		src.put_w({2'h3, 14'h1, 16'h0956});
		src.put_p(8'h90, 1, 1'h1);
		src.hdr(3'h2, 1'h1, 2'h0, 7'h1);
		src.put_w({2'h0, 14'h1, 16'h0956});
		src.put_p(8'hB0, 1, 1'h1);
		settle(2);
		cmp_seg(3'h2, 16'h0956, 4'hC, 8'h90, 1);
		obs.delete();
		rdchk(`SSF_DROP_CNT_OFFSET, 32'h1);
		rdchk(`SSF_FRAME_ERR_OFFSET, 32'h1);
		rdchk(`SSF_STATUS_OFFSET, 32'h4);
		// Short packet: middle piece cut after one of two bytes
		src.hdr(3'h2, 1'h1, 2'h0, 7'h1);
		src.put_w({2'h0, 14'h2, 16'h0956});
		src.put_p(8'hC0, 1, 1'h1);
		settle(1);
		cmp_seg(3'h2, 16'h0956, 4'h0, 8'hC0, 1);
		rdchk(`SSF_LEN_ERR_OFFSET, 32'h1);
	endtask
	// Main sequence after four cycles of reset
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		sc_regs();
		sc_segs();
		sc_span();
		sc_drop();
		report_and_stop();
	end
endmodule
`default_nettype wire
